// ---- src/prc_regs.svh ----
// Constants of the packet address routing control block.
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH
`define PRC_NPORTS        11
`define PRC_CFG_PORT      4'h0
`define PRC_EXT1_PORT     4'h9
`define PRC_EXT2_PORT     4'hA
`define PRC_LAST_PATH     8'h0A
`define PRC_FIRST_LOGICAL 8'h20
`define PRC_EOP_BIT       8
`define PRC_TBL_DEPTH     224
`define PRC_SWITCH_CYC    4
`define PRC_EXT_EXT_CYC   5
`define PRC_TC_OUT_CYC    8
`define PRC_TC_IN_CYC     6
`define PRC_TICK_LOW_CYC  3'h2
`define PRC_TX_CLK_RATIO  2
`endif

// ---- src/prc_pkg.sv ----
// Types and shared functions of the packet address routing control block.
`default_nettype none
`include "prc_regs.svh"
package prc_pkg;
  typedef enum logic [2:0] {
    prc_st_idle   = 3'b000,
    prc_st_lookup = 3'b001,
    prc_st_wait   = 3'b010,
    prc_st_head   = 3'b011,
    prc_st_fwd    = 3'b100,
    prc_st_spill  = 3'b101
  } prc_state_t;

  typedef struct packed {
    logic        valid;
    logic        prio;
    logic        strip;
    logic [10:0] mask;
  } prc_entry_t;

  // Lowest candidate port: bit 4 says one was found, bits 3:0 its number.
  function automatic logic [4:0] prc_pick(input logic [10:0] cand);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 10; i >= 0; i--) begin
      if (cand[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // True for an address in the path range.
  function automatic logic prc_is_path(input logic [7:0] a);
    return a < `PRC_FIRST_LOGICAL;
  endfunction
endpackage
`default_nettype wire

// ---- src/prc_route_table.sv ----
// Logical address routing table held in flip-flops.
`default_nettype none
`include "prc_regs.svh"
module prc_route_table (
  // Clock and reset.
  input  wire logic                mclk,
  input  wire logic                rst,
  // Write port.
  input  wire logic                wr,
  input  wire logic [7:0]          wr_addr,
  input  wire prc_pkg::prc_entry_t wr_entry,
  // Read port, answer one cycle later.
  input  wire logic [7:0]          rd_addr,
  output var  prc_pkg::prc_entry_t rd_entry
);
  import prc_pkg::*;

  prc_entry_t table_q [`PRC_TBL_DEPTH];
  logic [7:0] widx;
  logic [7:0] ridx;

  assign widx = wr_addr - `PRC_FIRST_LOGICAL;
  assign ridx = rd_addr - `PRC_FIRST_LOGICAL;

  // Entries clear to invalid, low priority, no header deletion.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `PRC_TBL_DEPTH; i++) begin
        table_q[i] <= '0;
      end
    end else if (wr && !prc_is_path(wr_addr)) begin
      table_q[widx] <= wr_entry;
      table_q[widx].mask[0] <= 1'b0;
    end
  end

  // Registered read; path addresses read as an empty entry.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_entry <= '0;
    end else if (prc_is_path(rd_addr)) begin
      rd_entry <= '0;
    end else begin
      rd_entry <= table_q[ridx];
    end
  end

  a_cfg_unreachable: assert property (@(posedge mclk) disable iff (rst)
    !rd_entry.mask[0]) else $error("table entry selects the configuration port");
endmodule
`default_nettype wire

// ---- src/prc_router_ctrl.sv ----
// Routing control: address decode, port connection, header strip and time-codes.
`default_nettype none
`include "prc_regs.svh"
// Contract
// - The first byte of each packet is its destination address.
// - Addresses 0 to 10 go to the port with the same number.
// - Addresses 32 to 255 go to ports chosen by the routing table.
// - Only path address zero reaches the configuration port.
// - Zero is configuration, 1-8 links, 9 and 10 external ports.
// - Bad addresses and empty external packets are spilled and flagged.
// - Every packet carries one of two priorities, high or low.
// - Path-addressed packets always get high priority.
// - Logical packets take priority from the table, low after reset.
// - Path packets lose their header; logical ones when the entry says so.
// - Path header deletion is fixed; logical deletion is set per entry.
// - A waiting input is connected to a freed port within four cycles.
// - External write to external not-empty takes at most five cycles.
// - Link receive to external not-empty adds at most eight cycles.
// - External write to link output adds at most four system cycles.
// - Link to link data adds at most eight system cycles.
// - Time-code link to link adds at most six system cycles.
// - Tick output rises within eight cycles of a received time-code.
// - A tick input rise yields a time-code request within six cycles from the counter, or from pins one ahead of it.
// - Time-code jitter is small; a pending code waits one character.
// - Transmit clock period is twice the configured bit period.
module prc_router_ctrl (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // Packet input, bit 8 marks the end of packet.
  input  wire logic        in_valid,
  input  wire logic [8:0]  in_data,
  input  wire logic [3:0]  in_src,
  output var  logic        in_ready,
  // Packet output towards the switch matrix.
  output var  logic        out_valid,
  output var  logic [8:0]  out_data,
  output var  logic [3:0]  out_port,
  input  wire logic        out_ready,
  input  wire logic [10:0] port_busy,
  // Route result and address errors.
  output var  logic        route_connect,
  output var  logic        route_prio,
  output var  logic        route_strip,
  output var  logic [10:0] addr_err,
  input  wire logic [10:0] addr_err_clr,
  // Routing table write port.
  input  wire logic        tbl_wr,
  input  wire logic [7:0]  tbl_addr,
  input  wire logic        tbl_valid,
  input  wire logic        tbl_prio,
  input  wire logic        tbl_strip,
  input  wire logic [10:0] tbl_mask,
  // Time-code interface.
  input  wire logic        tc_rx_valid,
  input  wire logic [7:0]  tc_rx_value,
  output var  logic        time_tick_out,
  output var  logic [7:0]  time_value_out,
  input  wire logic        time_tick_in,
  input  wire logic        sel_ext_time,
  input  wire logic [7:0]  ext_time_in,
  output var  logic        tc_tx_req,
  output var  logic [7:0]  tc_tx_value,
  // Link transmit rate.
  input  wire logic [7:0]  tx_bit_div,
  output var  logic        tx_clk_en
);
  import prc_pkg::*;

  // ****************************************************************
  // Address decode and routing table
  // ****************************************************************

  prc_state_t state;
  prc_state_t next_state;
  prc_entry_t wr_entry;
  prc_entry_t rd_entry;
  logic [7:0]  hdr;
  logic [3:0]  src;
  logic [10:0] mask;
  logic        accept;
  logic        drain;
  logic        next_out_valid;
  logic        load_head;
  logic        bad_addr;
  logic [10:0] next_mask;
  logic [4:0]  pick;
  logic        src_ext;
  logic        empty_pkt;
  logic [10:0] err_set;

  assign accept    = in_valid && in_ready;
  assign drain     = out_valid && out_ready;
  assign src_ext   = (in_src == `PRC_EXT1_PORT) || (in_src == `PRC_EXT2_PORT);
  assign empty_pkt = (state == prc_st_idle) && accept && in_data[`PRC_EOP_BIT];
  assign wr_entry  = '{valid: tbl_valid, prio: tbl_prio, strip: tbl_strip, mask: tbl_mask};
  assign pick      = prc_pick(mask & ~port_busy);

  prc_route_table u_table (
    .mclk     (mclk),
    .rst      (rst),
    .wr       (tbl_wr),
    .wr_addr  (tbl_addr),
    .wr_entry (wr_entry),
    .rd_addr  (in_data[7:0]),
    .rd_entry (rd_entry)
  );

  // Path addresses map straight to a port; logical ones use the table entry.
  always_comb begin
    if (prc_is_path(hdr)) begin
      next_mask = 11'h001 << hdr[3:0];
      bad_addr  = hdr > `PRC_LAST_PATH;
    end else begin
      next_mask = rd_entry.mask;
      bad_addr  = !rd_entry.valid;
    end
  end

  // ****************************************************************
  // Packet sequencing
  // ****************************************************************

  // The header slot can load once the output register is free.
  assign load_head = (state == prc_st_head) && (!out_valid || out_ready);

  // Next state and next occupancy of the output register.
  always_comb begin
    next_state     = state;
    next_out_valid = (out_valid && !out_ready) || load_head ||
                     ((state == prc_st_fwd) && accept);
    unique case (state)
      prc_st_idle: begin
        if (accept && !in_data[`PRC_EOP_BIT]) begin
          next_state = prc_st_lookup;
        end
      end
      prc_st_lookup: begin
        next_state = bad_addr ? prc_st_spill : prc_st_wait;
      end
      prc_st_wait: begin
        // The previous packet's last byte must leave the output stage first.
        if (pick[4] && !out_valid) begin
          next_state = route_strip ? prc_st_fwd : prc_st_head;
        end
      end
      prc_st_head: begin
        if (load_head) begin
          next_state = prc_st_fwd;
        end
      end
      prc_st_fwd, prc_st_spill: begin
        if (accept && in_data[`PRC_EOP_BIT]) begin
          next_state = prc_st_idle;
        end
      end
      default: begin
        next_state = prc_st_idle;
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= prc_st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Input is taken when idle, when spilling, or when forwarding with the output slot free.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= (next_state == prc_st_idle) || (next_state == prc_st_spill) ||
                  ((next_state == prc_st_fwd) && !next_out_valid);
    end
  end

  // Header byte and source port are held for the whole packet.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hdr <= 8'h00;
      src <= 4'h0;
    end else if ((state == prc_st_idle) && accept) begin
      hdr <= in_data[7:0];
      src <= in_src;
    end
  end

  // Route attributes settle in the lookup cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask        <= 11'h000;
      route_prio  <= 1'b0;
      route_strip <= 1'b0;
    end else if (state == prc_st_lookup) begin
      mask        <= next_mask;
      route_prio  <= prc_is_path(hdr) ? 1'b1 : rd_entry.prio;
      route_strip <= prc_is_path(hdr) ? 1'b1 : rd_entry.strip;
    end
  end

  // Connect to the lowest free port of the candidate group once the output stage is empty.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      route_connect <= 1'b0;
      out_port      <= 4'h0;
    end else begin
      route_connect <= (state == prc_st_wait) && pick[4] && !out_valid;
      if ((state == prc_st_wait) && pick[4] && !out_valid) begin
        out_port <= pick[3:0];
      end
    end
  end

  // One output stage keeps the forwarding share to a single cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= 9'h000;
    end else begin
      out_valid <= next_out_valid;
      if (load_head) begin
        out_data <= {1'b0, hdr};
      end else if ((state == prc_st_fwd) && accept) begin
        out_data <= in_data;
      end
    end
  end

  // Sticky address errors per receiving port; a new error beats a clear.
  assign err_set = ((state == prc_st_lookup) && bad_addr) ? (11'h001 << src) :
                   (empty_pkt && src_ext) ? (11'h001 << in_src) : 11'h000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_err <= 11'h000;
    end else begin
      addr_err <= (addr_err & ~addr_err_clr) | err_set;
    end
  end

  // ****************************************************************
  // Time-codes
  // ****************************************************************

  logic [2:0] tick_cnt;
  logic       tick_in_q;
  logic [5:0] tc_ctr;
  logic [5:0] tc_next;
  logic       tick_rise;

  assign tick_rise = time_tick_in && !tick_in_q;
  assign tc_next   = tc_ctr + 6'h01;

  // Received code: value out, tick low, then high once the value is stable.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      time_tick_out  <= 1'b0;
      time_value_out <= 8'h00;
      tick_cnt       <= 3'h0;
    end else if (tc_rx_valid) begin
      time_value_out <= tc_rx_value;
      time_tick_out  <= 1'b0;
      tick_cnt       <= `PRC_TICK_LOW_CYC;
    end else if (tick_cnt != 3'h0) begin
      tick_cnt <= tick_cnt - 3'h1;
      if (tick_cnt == 3'h1) begin
        time_tick_out <= 1'b1;
      end
    end
  end

  // Received codes are passed on; a tick input edge builds one from the counter, or from the pins when they are one ahead of it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_in_q   <= 1'b0;
      tc_ctr      <= 6'h00;
      tc_tx_req   <= 1'b0;
      tc_tx_value <= 8'h00;
    end else begin
      tick_in_q <= time_tick_in;
      tc_tx_req <= 1'b0;
      if (tc_rx_valid) begin
        tc_ctr      <= tc_rx_value[5:0];
        tc_tx_req   <= 1'b1;
        tc_tx_value <= tc_rx_value;
      end else if (tick_rise && sel_ext_time) begin
        if (ext_time_in[5:0] == tc_next) begin
          tc_ctr      <= tc_next;
          tc_tx_req   <= 1'b1;
          tc_tx_value <= ext_time_in;
        end
      end else if (tick_rise) begin
        tc_ctr      <= tc_next;
        tc_tx_req   <= 1'b1;
        tc_tx_value <= {ext_time_in[7:6], tc_next};
      end
    end
  end

  // ****************************************************************
  // Transmit clock enable
  // ****************************************************************

  logic [7:0] div_cnt;
  logic       half;

  // A bit lasts tx_bit_div+1 cycles; the clock enable fires every second bit.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt   <= 8'h00;
      half      <= 1'b0;
      tx_clk_en <= 1'b0;
    end else begin
      tx_clk_en <= 1'b0;
      if (div_cnt >= tx_bit_div) begin
        div_cnt   <= 8'h00;
        half      <= !half;
        tx_clk_en <= half;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  logic [9:0] gap;
  logic       gap_armed;

  // Cycles since the last transmit clock enable.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap       <= 10'h000;
      gap_armed <= 1'b0;
    end else if (tx_clk_en) begin
      gap       <= 10'h001;
      gap_armed <= 1'b1;
    end else begin
      gap <= gap + 10'h001;
    end
  end

  a_path_port: assert property (@(posedge mclk) disable iff (rst)
    route_connect && prc_is_path(hdr) |-> out_port == hdr[3:0])
    else $error("path packet sent to the wrong port");

  a_cfg_logical: assert property (@(posedge mclk) disable iff (rst)
    route_connect && !prc_is_path(hdr) |-> out_port != `PRC_CFG_PORT)
    else $error("logical packet reached the configuration port");

  a_path_attrs: assert property (@(posedge mclk) disable iff (rst)
    route_connect && prc_is_path(hdr) |-> route_prio && route_strip)
    else $error("path packet lacks high priority or header deletion");

  a_bad_spill: assert property (@(posedge mclk) disable iff (rst)
    state == prc_st_lookup && bad_addr |=> state == prc_st_spill && addr_err[src])
    else $error("invalid address not spilled and flagged");

  a_switch_time: assert property (@(posedge mclk) disable iff (rst)
    state == prc_st_wait && |(mask & ~port_busy) && !out_valid |-> ##[1:4] route_connect)
    else $error("free port not connected in time");

  a_fwd_latency: assert property (@(posedge mclk) disable iff (rst)
    state == prc_st_fwd && accept |=> out_valid && out_data == $past(in_data))
    else $error("forwarded byte late or altered");

  a_strip_head: assert property (@(posedge mclk) disable iff (rst)
    state == prc_st_wait && pick[4] && !out_valid && route_strip |=> state == prc_st_fwd ##1
    !(out_valid && out_data == {1'b0, hdr} && $past(state) == prc_st_head))
    else $error("stripped header was forwarded");

  a_tick_rise: assert property (@(posedge mclk) disable iff (rst)
    tc_rx_valid ##1 !tc_rx_valid [*2] |-> ##[0:6] time_tick_out)
    else $error("tick output did not rise in time");

  a_tick_req: assert property (@(posedge mclk) disable iff (rst)
    $rose(time_tick_in) && !sel_ext_time && !tc_rx_valid |-> ##[1:6] tc_tx_req)
    else $error("tick input produced no time-code request");

  a_tc_forward: assert property (@(posedge mclk) disable iff (rst)
    tc_rx_valid |=> tc_tx_req && tc_tx_value == $past(tc_rx_value))
    else $error("received time-code not passed on");

  a_tx_ratio: assert property (@(posedge mclk) disable iff (rst)
    tx_clk_en && gap_armed && $stable(tx_bit_div) |-> gap == 10'({2'b00, tx_bit_div} + 10'h001) * 10'h002)
    else $error("transmit clock period is not twice the bit period");
endmodule
`default_nettype wire

// ---- verif/prc_sink_model.sv ----
// Output side model: takes bytes with random stalls and reports ports busy on request.
`default_nettype none
module prc_sink_model (
  // Clock.
  input  wire logic        mclk,
  // Byte stream from the routing control.
  input  wire logic        out_valid,
  input  wire logic [8:0]  out_data,
  output var  logic        out_ready,
  // Port occupancy asked for by the bench.
  input  wire logic [10:0] busy_req,
  output var  logic [10:0] port_busy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [8:0]  got[$];
  logic [31:0] seed = 32'h9E3779B9;

  // A byte is taken on each rising edge where valid and ready meet.
  always @(posedge mclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got.push_back(out_data);
    end
  end

  // Ready and busy change at the falling edge; ready drops on random cycles to stall.
  always @(negedge mclk) begin
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    out_ready <= seed[3] | seed[6];
    port_busy <= busy_req;
  end
endmodule
`default_nettype wire

// ---- verif/prc_router_ctrl_tb.sv ----
// Self-checking bench of the packet address routing control.
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module prc_router_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk, rst, in_valid, in_ready, out_valid, out_ready, route_connect;
  logic        route_prio, route_strip, tbl_wr, tbl_valid, tbl_prio, tbl_strip;
  logic        tc_rx_valid, time_tick_out, time_tick_in, sel_ext_time, tc_tx_req, tx_clk_en;
  logic [8:0]  in_data, out_data;
  logic [3:0]  in_src, out_port;
  logic [10:0] port_busy, addr_err, addr_err_clr, tbl_mask, busy_req;
  logic [7:0]  tbl_addr, tc_rx_value, time_value_out, ext_time_in, tc_tx_value, tx_bit_div;
  logic [31:0] xs = 32'h0000001A;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_conn = 0;
  int          cyc = 0;
  int          c_cyc = 0;

  prc_router_ctrl i_dut (.mclk(mclk), .rst(rst), .in_valid(in_valid), .in_data(in_data),
    .in_src(in_src), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_port(out_port), .out_ready(out_ready), .port_busy(port_busy),
    .route_connect(route_connect), .route_prio(route_prio), .route_strip(route_strip),
    .addr_err(addr_err), .addr_err_clr(addr_err_clr), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
    .tbl_valid(tbl_valid), .tbl_prio(tbl_prio), .tbl_strip(tbl_strip), .tbl_mask(tbl_mask),
    .tc_rx_valid(tc_rx_valid), .tc_rx_value(tc_rx_value), .time_tick_out(time_tick_out),
    .time_value_out(time_value_out), .time_tick_in(time_tick_in),
    .sel_ext_time(sel_ext_time), .ext_time_in(ext_time_in), .tc_tx_req(tc_tx_req),
    .tc_tx_value(tc_tx_value), .tx_bit_div(tx_bit_div), .tx_clk_en(tx_clk_en));

  prc_sink_model u_sink (.mclk(mclk), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .busy_req(busy_req), .port_busy(port_busy));

  // Fixed-rate system clock of 25 ns.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Cycle count and connection monitor, sampled where outputs are settled.
  always @(posedge mclk) cyc++;
  always @(negedge mclk) begin
    if (route_connect === 1'b1) begin
      n_conn++;
      c_cyc = cyc;
    end
  end

  // Repeatable xorshift source.
  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction

  // Lowest-numbered link or external port of a mask; port zero never counts.
  function automatic logic [3:0] low_port(input logic [10:0] m);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 10; i >= 1; i--) begin
      if (m[i]) p = 4'(i);
    end
    return p;
  endfunction

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Offer one byte and hold it until the edge that takes it.
  task automatic send(input logic [8:0] b);
    int k;
    k = 0;
    in_valid = 1'b1;
    in_data = b;
    while (in_ready !== 1'b1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    if (k >= 200) `CHK("byte taken", 1, 0)
  endtask

  // Expect the error flag of a port, then clear it.
  task automatic chk_err(input logic [3:0] src);
    repeat (10) @(negedge mclk);
    `CHK("error flag", 1'b1, addr_err[src])
    addr_err_clr = 11'(11'h001 << src);
    @(negedge mclk);
    addr_err_clr = 11'h000;
    @(negedge mclk);
    `CHK("error cleared", 1'b0, addr_err[src])
  endtask

  // One packet of header, two data bytes and an end marker, with its expected route.
  task automatic run_pkt(input logic [7:0] hdr, input logic [3:0] src, input logic ok,
                         input logic [3:0] ep, input logic epr, input logic est,
                         input logic hold);
    logic [8:0]  exp_q[$];
    logic [31:0] v;
    int          t0;
    int          k;
    u_sink.got.delete();
    n_conn = 0;
    t0 = 0;
    in_src = src;
    if (!est) exp_q.push_back({1'b0, hdr});
    if (hold) busy_req = 11'(11'h001 << ep);
    send({1'b0, hdr});
    if (hold) begin
      repeat (6) @(negedge mclk);
      `CHK("connect while busy", 0, n_conn)
      busy_req = 11'h000;
      t0 = cyc;
    end
    for (k = 0; k < 3; k++) begin
      v = rnd();
      exp_q.push_back((k == 2) ? 9'h100 : {1'b0, v[7:0]});
      send(exp_q[$]);
    end
    in_valid = 1'b0;
    if (ok) begin
      k = 0;
      while (u_sink.got.size() < exp_q.size() && k < 300) begin
        @(negedge mclk);
        k++;
      end
      `CHK("connects", 1, n_conn)
      `CHK("out_port", ep, out_port)
      `CHK("route_prio", epr, route_prio)
      `CHK("route_strip", est, route_strip)
      `CHK("byte count", exp_q.size(), u_sink.got.size())
      foreach (exp_q[i]) `CHK("out byte", exp_q[i], u_sink.got[i])
      if (hold) `CHK("switch time", 1, (c_cyc - t0 <= 4))
    end else begin
      chk_err(src);
      `CHK("spilled", 0, n_conn + u_sink.got.size())
    end
  endtask

  // Watchdog: the whole sequence needs far fewer cycles than this.
  initial begin
    #(40000 * 25);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] v;
    logic [10:0] m;
    logic [7:0]  la, tcv;
    int          k, t0, seen;
    rst = 1'b1;
    {in_valid, tbl_wr, tbl_valid, tbl_prio, tbl_strip, tc_rx_valid} = 6'h00;
    {time_tick_in, sel_ext_time} = 2'h0;
    {in_data, in_src, addr_err_clr, tbl_mask, busy_req} = 46'h0;
    {tbl_addr, tc_rx_value, ext_time_in} = 24'h000000;
    v = rnd();
    tx_bit_div = {5'h00, v[2:0]};
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    // Every path port, one of them released late.
    for (int a = 0; a <= 10; a++) begin
      v = rnd();
      run_pkt(8'(a), 4'(v % 11), 1'b1, 4'(a), 1'b1, 1'b1, a == 3);
    end
    // Invalid path addresses, both ends of the range and one between.
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      la = (i == 0) ? 8'h0B : (i == 1) ? 8'h1F : 8'(11 + v % 21);
      run_pkt(la, 4'(v[7:0] % 11), 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
    end
    // Empty packets from the external ports.
    for (int s = 9; s <= 10; s++) begin
      in_src = 4'(s);
      send(9'h100);
      in_valid = 1'b0;
      chk_err(4'(s));
    end
    // Logical addresses: refused before the entry is written, routed after.
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      la = (i == 5) ? 8'hFF : 8'(32 + i * 37);
      run_pkt(la, 4'(v[31:24] % 11), 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
      m = v[10:0];
      if (m[10:1] == 10'h000) m[10] = 1'b1;
      {tbl_addr, tbl_valid, tbl_prio, tbl_strip, tbl_mask} = {la, 1'b1, v[11], v[12], m};
      tbl_wr = 1'b1;
      @(negedge mclk);
      tbl_wr = 1'b0;
      @(negedge mclk);
      run_pkt(la, 4'(v[31:24] % 11), 1'b1, low_port(m), v[11], v[12], 1'b0);
    end
    // Transmit enable period.
    k = 0;
    while (tx_clk_en !== 1'b1 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    t0 = cyc;
    @(negedge mclk);
    while (tx_clk_en !== 1'b1 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    `CHK("tx period", 2 * (tx_bit_div + 1), cyc - t0)
    // Received time-codes reach the tick output and are passed on; twice, so the tick falls.
    repeat (2) begin
      v = rnd();
      tcv = v[7:0];
      tc_rx_value = tcv;
      tc_rx_valid = 1'b1;
      @(negedge mclk);
      `CHK("code forward", 1'b1, tc_tx_req)
      `CHK("forward value", tcv, tc_tx_value)
      tc_rx_valid = 1'b0;
      @(negedge mclk);
      `CHK("tick low", 1'b0, time_tick_out)
      `CHK("time value", tcv, time_value_out)
      k = 0;
      while (time_tick_out !== 1'b1 && k < 6) begin
        @(negedge mclk);
        k++;
      end
      `CHK("tick rise", 1'b1, time_tick_out)
    end
    // Tick input with the internal counter as source.
    v = rnd();
    ext_time_in = v[7:0];
    time_tick_in = 1'b1;
    k = 0;
    while (tc_tx_req !== 1'b1 && k < 6) begin
      @(negedge mclk);
      k++;
    end
    `CHK("tick request", 1'b1, tc_tx_req)
    `CHK("code value", {v[7:6], 6'(tcv[5:0] + 6'h01)}, tc_tx_value)
    time_tick_in = 1'b0;
    repeat (4) @(negedge mclk);
    // External code that is not one ahead of the counter is not sent.
    ext_time_in = {2'b00, 6'(tcv[5:0] + 6'h03)};
    sel_ext_time = 1'b1;
    time_tick_in = 1'b1;
    seen = 0;
    repeat (8) begin
      @(negedge mclk);
      if (tc_tx_req === 1'b1) seen = 1;
    end
    `CHK("bad code sent", 0, seen)
    time_tick_in = 1'b0;
    repeat (4) @(negedge mclk);
    // External code one ahead of the counter is sent as given.
    ext_time_in = {v[7:6], 6'(tcv[5:0] + 6'h02)};
    time_tick_in = 1'b1;
    @(negedge mclk);
    `CHK("good code sent", 1'b1, tc_tx_req)
    `CHK("good code value", ext_time_in, tc_tx_value)
    time_tick_in = 1'b0;
    repeat (4) @(negedge mclk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
